// File: logic/ipr_pkg.sv
package ipr_pkg;

    // ****************************************************************
    // Register offsets (byte addresses on the plain register port)
    // ****************************************************************
    localparam logic [3:0] OFS_PIN_INPUT_STATUS = 4'h0;
    localparam logic [3:0] OFS_DEBOUNCE_ENABLE = 4'h1;
    localparam logic [3:0] OFS_EDGE_SELECT = 4'h2;
    localparam logic [3:0] OFS_PULLUP_ENABLE = 4'h3;
    localparam logic [3:0] OFS_RESET_CONFIG_LOW = 4'h4;
    localparam logic [3:0] OFS_RESET_CONFIG_HIGH = 4'h5;
    localparam logic [3:0] OFS_SYSTEM_MISC = 4'h6;
    localparam logic [3:0] OFS_SYSTEM_CLOCK = 4'h7;

    // ****************************************************************
    // Field positions in system_misc_config / system_clock_config
    // ****************************************************************
    localparam int MISC_FAST_DEBOUNCE_BIT = 0;
    localparam int MISC_RC_FROM_PIN_BIT = 1;
    localparam int CLK_RC_ENABLE_BIT = 0;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] DEBOUNCE_RESET = 8'h00;
    localparam logic [7:0] EDGE_RESET = 8'h00;
    localparam logic [7:0] PULLUP_RESET = 8'h00;
    localparam logic [7:0] RESCFG_RESET = 8'h00;
    localparam logic [7:0] MISC_RESET = 8'h00;
    localparam logic [7:0] CLOCK_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ****************************************************************
    // Interrupt and event routing masks
    // ****************************************************************
    localparam logic [7:0] MID_IRQ_MASK = 8'h33;
    localparam logic [7:0] LOW_IRQ_MASK = 8'hcc;
    localparam int EVT_PIN0_POS = 0;
    localparam int EVT_PIN1_POS = 4;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_SYS_HZ = 10000000;
    localparam int DEB_SLOW_HZ = 256;
    localparam int DEB_FAST_HZ = 8000;
    localparam int DEB_SLOW_CYCLES = CLK_SYS_HZ / DEB_SLOW_HZ;
    localparam int DEB_FAST_CYCLES = CLK_SYS_HZ / DEB_FAST_HZ;

    typedef struct packed {
        logic [7:0] pin_state;
        logic [7:0] pin_irq;
    } ipr_pin_view_s;

endpackage

// File: logic/ipr_debounce_tick.sv
`timescale 1ns/1ps

// ********************************************************************
// Debounce sample enable divider
// ********************************************************************
module ipr_debounce_tick #(
    parameter int SLOW_CYCLES = ipr_pkg::DEB_SLOW_CYCLES,
    parameter int FAST_CYCLES = ipr_pkg::DEB_FAST_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic fast_debounce_select,
    output logic tick
);
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic tick_next;
    logic tick_reg;
    logic [15:0] limit;

    always_comb begin
        limit = fast_debounce_select ? 16'(FAST_CYCLES - 1) : 16'(SLOW_CYCLES - 1);
        if (cnt_reg >= limit) begin
            cnt_next = 16'h0000;
            tick_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + 16'h0001;
            tick_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= 16'h0000;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;
endmodule

// File: logic/ipr_pin_filter.sv
`timescale 1ns/1ps

// ********************************************************************
// Per-pin synchroniser, debouncer and edge detector
// ********************************************************************
module ipr_pin_filter (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic pin_async,
    input wire logic sample_tick,
    input wire logic debounce_en,
    input wire logic edge_negative,
    output logic pin_state,
    output logic pin_irq
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic clean_reg;
    logic clean_next;
    logic samp_reg;
    logic samp_next;
    logic deb_reg;
    logic deb_next;
    logic pol_reg;
    logic pol_next;
    logic irq_reg;
    logic irq_next;
    logic sel;

    always_comb begin
        // Stage 2 and 3 must agree before the level is trusted
        clean_next = (s2_reg == s3_reg) ? s3_reg : clean_reg;
        samp_next = samp_reg;
        deb_next = deb_reg;
        if (sample_tick) begin
            samp_next = clean_reg;
            if (samp_reg == clean_reg) begin
                deb_next = clean_reg;
            end
        end
        sel = debounce_en ? deb_reg : clean_reg;
        // Polarity first, then rising detect: an edge-select write may fire
        pol_next = sel ^ edge_negative;
        irq_next = pol_next & ~pol_reg;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            clean_reg <= 1'b0;
            samp_reg <= 1'b0;
            deb_reg <= 1'b0;
            pol_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            s1_reg <= pin_async;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            clean_reg <= clean_next;
            samp_reg <= samp_next;
            deb_reg <= deb_next;
            pol_reg <= pol_next;
            irq_reg <= irq_next;
        end
    end

    assign pin_state = sel;
    assign pin_irq = irq_reg;
endmodule

// File: logic/ipr_input_port.sv
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps

// Contract
// - Pins 0,1,4,5 mid; 2,3,6,7 low irq
// - Pin0 irq to event 0, pin1 event 4
// - Read inputs, debounced where enabled
// - Per-pin debounce enables, cleared at reset
// - Accept value after two equal samples
// - Sample clock 256 Hz or 8 kHz
// - Pull-up per bit, off at start
// - Irq on rising or falling edge
// - Edge select resets to rising
// - Debounced pins use debounced value for irq
// - Edge detect after polarity applied
// - Pins 0-3 feed counter clocks
// - Port reset is AND of terms
// - Config pair selects 0, pin, not pin, 1
// - All ones in both: software reset
// - Pin0 high with option sets rc enable
// - Edge bit 0 positive, 1 negative
// - Status register returns pins, bit7 pin7
module ipr_input_port #(
    parameter int PINS = 8,
    parameter int SLOW_CYCLES = ipr_pkg::DEB_SLOW_CYCLES,
    parameter int FAST_CYCLES = ipr_pkg::DEB_FAST_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [PINS-1:0] input_pins,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic [PINS-1:0] pullup_enable_bits,
    output logic [PINS-1:0] pin_irq_lines,
    output logic [PINS-1:0] mid_priority_irq_flags,
    output logic [PINS-1:0] low_priority_irq_flags,
    output logic [7:0] event_flags,
    output logic [3:0] counter_clock_images,
    output logic port_reset_request,
    output logic rc_oscillator_enable
);

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [7:0] debounce_enable_bits_reg;
    logic [7:0] debounce_enable_bits_next;
    logic [7:0] edge_select_bits_reg;
    logic [7:0] edge_select_bits_next;
    logic [7:0] pullup_reg;
    logic [7:0] pullup_next;
    logic [7:0] reset_config_low_reg;
    logic [7:0] reset_config_low_next;
    logic [7:0] reset_config_high_reg;
    logic [7:0] reset_config_high_next;
    logic [7:0] system_misc_config_reg;
    logic [7:0] system_misc_config_next;
    logic rc_en_reg;
    logic rc_en_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rst_req_reg;
    logic rst_req_next;

    ipr_pkg::ipr_pin_view_s view;
    logic [7:0] pin_status;
    logic [7:0] pin_reset_term;
    logic sample_tick;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction

    always_comb begin
        pin_status = 8'h00;
        pin_status[PINS-1:0] = view.pin_state[PINS-1:0];
    end

    always_comb begin
        debounce_enable_bits_next = debounce_enable_bits_reg;
        edge_select_bits_next = edge_select_bits_reg;
        pullup_next = pullup_reg;
        reset_config_low_next = reset_config_low_reg;
        reset_config_high_next = reset_config_high_reg;
        system_misc_config_next = system_misc_config_reg;
        rc_en_next = rc_en_reg;
        if (reg_wr) begin
            if (hit(reg_addr, ipr_pkg::OFS_DEBOUNCE_ENABLE)) begin
                debounce_enable_bits_next = reg_wdata;
            end
            if (hit(reg_addr, ipr_pkg::OFS_EDGE_SELECT)) begin
                edge_select_bits_next = reg_wdata;
            end
            if (hit(reg_addr, ipr_pkg::OFS_PULLUP_ENABLE)) begin
                pullup_next = reg_wdata;
            end
            if (hit(reg_addr, ipr_pkg::OFS_RESET_CONFIG_LOW)) begin
                reset_config_low_next = reg_wdata;
            end
            if (hit(reg_addr, ipr_pkg::OFS_RESET_CONFIG_HIGH)) begin
                reset_config_high_next = reg_wdata;
            end
            if (hit(reg_addr, ipr_pkg::OFS_SYSTEM_MISC)) begin
                system_misc_config_next = reg_wdata;
            end
            if (hit(reg_addr, ipr_pkg::OFS_SYSTEM_CLOCK)) begin
                rc_en_next = reg_wdata[ipr_pkg::CLK_RC_ENABLE_BIT];
            end
        end
        // Hardware set wins over a software clear in the same cycle
        if (system_misc_config_reg[ipr_pkg::MISC_RC_FROM_PIN_BIT] && pin_status[0]) begin
            rc_en_next = 1'b1;
        end
    end

    always_comb begin
        rdata_next = ipr_pkg::UNMAPPED_READ;
        if (reg_rd) begin
            case (reg_addr)
                ipr_pkg::OFS_PIN_INPUT_STATUS: rdata_next = pin_status;
                ipr_pkg::OFS_DEBOUNCE_ENABLE: rdata_next = debounce_enable_bits_reg;
                ipr_pkg::OFS_EDGE_SELECT: rdata_next = edge_select_bits_reg;
                ipr_pkg::OFS_PULLUP_ENABLE: rdata_next = pullup_reg;
                ipr_pkg::OFS_RESET_CONFIG_LOW: rdata_next = reset_config_low_reg;
                ipr_pkg::OFS_RESET_CONFIG_HIGH: rdata_next = reset_config_high_reg;
                ipr_pkg::OFS_SYSTEM_MISC: rdata_next = system_misc_config_reg;
                ipr_pkg::OFS_SYSTEM_CLOCK: rdata_next = {7'h00, rc_en_reg};
                default: rdata_next = ipr_pkg::UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            debounce_enable_bits_reg <= ipr_pkg::DEBOUNCE_RESET;
            edge_select_bits_reg <= ipr_pkg::EDGE_RESET;
            pullup_reg <= ipr_pkg::PULLUP_RESET;
            reset_config_low_reg <= ipr_pkg::RESCFG_RESET;
            reset_config_high_reg <= ipr_pkg::RESCFG_RESET;
            system_misc_config_reg <= ipr_pkg::MISC_RESET;
            rc_en_reg <= ipr_pkg::CLOCK_RESET[ipr_pkg::CLK_RC_ENABLE_BIT];
            rdata_reg <= 8'h00;
        end else begin
            debounce_enable_bits_reg <= debounce_enable_bits_next;
            edge_select_bits_reg <= edge_select_bits_next;
            pullup_reg <= pullup_next;
            reset_config_low_reg <= reset_config_low_next;
            reset_config_high_reg <= reset_config_high_next;
            system_misc_config_reg <= system_misc_config_next;
            rc_en_reg <= rc_en_next;
            rdata_reg <= rdata_next;
        end
    end

    // ****************************************************************
    // Pin pipelines
    // ****************************************************************
    ipr_debounce_tick #(
        .SLOW_CYCLES(SLOW_CYCLES),
        .FAST_CYCLES(FAST_CYCLES)
    ) u_tick (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .fast_debounce_select(system_misc_config_reg[ipr_pkg::MISC_FAST_DEBOUNCE_BIT]),
        .tick(sample_tick)
    );

    generate
        for (genvar i = 0; i < PINS; i++) begin : g_pin
            ipr_pin_filter u_pin (
                .clk_sys(clk_sys),
                .rstn(rstn),
                .pin_async(input_pins[i]),
                .sample_tick(sample_tick),
                .debounce_en(debounce_enable_bits_reg[i]),
                .edge_negative(edge_select_bits_reg[i]),
                .pin_state(view.pin_state[i]),
                .pin_irq(view.pin_irq[i])
            );
        end
        for (genvar j = PINS; j < 8; j++) begin : g_pad
            assign view.pin_state[j] = 1'b0;
            assign view.pin_irq[j] = 1'b0;
        end
    endgenerate

    // ****************************************************************
    // Port reset: AND of per-pin terms
    // ****************************************************************
    generate
        for (genvar k = 0; k < 8; k++) begin : g_term
            always_comb begin
                // Pair 11 forces 1, so both registers at all ones resets outright
                case ({reset_config_high_reg[k], reset_config_low_reg[k]})
                    2'b00: pin_reset_term[k] = 1'b0;
                    2'b01: pin_reset_term[k] = pin_status[k];
                    2'b10: pin_reset_term[k] = ~pin_status[k];
                    default: pin_reset_term[k] = 1'b1;
                endcase
            end
        end
    endgenerate

    // Registered so a decode glitch while config is rewritten cannot pulse reset
    always_comb begin
        rst_req_next = &pin_reset_term;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_req_reg <= 1'b0;
        end else begin
            rst_req_reg <= rst_req_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign reg_rdata = rdata_reg;
    assign pullup_enable_bits = pullup_reg[PINS-1:0];
    assign pin_irq_lines = view.pin_irq[PINS-1:0];
    assign mid_priority_irq_flags = view.pin_irq[PINS-1:0] & ipr_pkg::MID_IRQ_MASK[PINS-1:0];
    assign low_priority_irq_flags = view.pin_irq[PINS-1:0] & ipr_pkg::LOW_IRQ_MASK[PINS-1:0];

    always_comb begin
        event_flags = 8'h00;
        event_flags[ipr_pkg::EVT_PIN0_POS] = view.pin_irq[0];
        event_flags[ipr_pkg::EVT_PIN1_POS] = view.pin_irq[1];
    end

    assign counter_clock_images = pin_status[3:0];
    assign port_reset_request = rst_req_reg;
    assign rc_oscillator_enable = rc_en_reg;

endmodule

// File: testbench/ipr_pin_source.sv
`timescale 1ns/1ps

// ************************************************************
// External drivers on the input pins, with the on-chip pull-ups
// ************************************************************
module ipr_pin_source (
    input wire logic clk_sys,
    input wire logic [7:0] drive_en,
    input wire logic [7:0] drive_val,
    input wire logic [7:0] pullup_enable_bits,
    output logic [7:0] input_pins
);
    logic [7:0] float_reg = 8'h00;

    // A released pin without pull-up wanders, so no check can lean on it
    always_ff @(posedge clk_sys) begin
        float_reg <= ~float_reg;
    end

    assign input_pins = (drive_en & drive_val) | (~drive_en & (pullup_enable_bits | float_reg));
endmodule

// File: testbench/ipr_input_port_sva.sv
`timescale 1ns/1ps

// ************************************************************
// Port checker
// ************************************************************
module ipr_input_port_sva (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [7:0] input_pins,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] pullup_enable_bits,
    input wire logic [7:0] pin_irq_lines,
    input wire logic [7:0] mid_priority_irq_flags,
    input wire logic [7:0] low_priority_irq_flags,
    input wire logic [7:0] event_flags,
    input wire logic [3:0] counter_clock_images,
    input wire logic port_reset_request,
    input wire logic rc_oscillator_enable
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_wr(logic [3:0] a, logic [7:0] d);
        reg_wr && reg_addr == a && reg_wdata == d;
    endsequence

    a_mid_route: assert property (mid_priority_irq_flags == (pin_irq_lines & 8'h33))
        else $error("mid priority flags misrouted");
    a_low_route: assert property (low_priority_irq_flags == (pin_irq_lines & 8'hcc))
        else $error("low priority flags misrouted");
    a_event_route: assert property (event_flags == {3'h0, pin_irq_lines[1], 3'h0, pin_irq_lines[0]})
        else $error("event flags misrouted");
    a_irq_one_cycle: assert property (|pin_irq_lines |=> (pin_irq_lines & $past(pin_irq_lines)) == 8'h00)
        else $error("irq pulse longer than one cycle");
    a_status_read: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata[3:0] == $past(counter_clock_images))
        else $error("status read disagrees with clock images");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    a_pullup_write: assert property (reg_wr && reg_addr == 4'h3 |=> pullup_enable_bits == $past(reg_wdata))
        else $error("pull-up bits not written");
    a_soft_reset: assert property (s_wr(4'h4, 8'hff) ##2 s_wr(4'h5, 8'hff) |-> ##[1:3] port_reset_request)
        else $error("software reset not raised");
    a_reset_inhibit: assert property (s_wr(4'h4, 8'h00) ##2 s_wr(4'h5, 8'h00) |-> ##[1:3] !port_reset_request)
        else $error("reset request not inhibited");
    a_rc_hold: assert property (rc_oscillator_enable && !(reg_wr && reg_addr == 4'h7) |=> rc_oscillator_enable)
        else $error("rc enable dropped without write");
endmodule

bind ipr_input_port ipr_input_port_sva u_sva (.clk_sys(clk_sys), .rstn(rstn), .input_pins(input_pins),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pullup_enable_bits(pullup_enable_bits), .pin_irq_lines(pin_irq_lines),
    .mid_priority_irq_flags(mid_priority_irq_flags), .low_priority_irq_flags(low_priority_irq_flags),
    .event_flags(event_flags), .counter_clock_images(counter_clock_images),
    .port_reset_request(port_reset_request), .rc_oscillator_enable(rc_oscillator_enable));

// File: testbench/ipr_input_port_bench.sv
`timescale 1ns/1ps

// ************************************************************
// Bench
// ************************************************************
module ipr_input_port_bench;
    typedef struct packed {
        logic [3:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } ipr_row_s;

    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] drive_en = 8'hff;
    logic [7:0] drive_val = 8'h00;
    logic [7:0] input_pins, reg_rdata, pullup_enable_bits, pin_irq_lines;
    logic [7:0] mid_priority_irq_flags, low_priority_irq_flags, event_flags;
    logic [3:0] counter_clock_images;
    logic port_reset_request, rc_oscillator_enable;
    logic [7:0] irq_acc, mid_acc, low_acc, evt_acc, rd_val;
    int bad_count = 0;
    int checks_done = 0;
    ipr_row_s rows [7] = '{'{4'h1, 8'h5a, 8'h5a}, '{4'h2, 8'ha5, 8'ha5}, '{4'h3, 8'h3c, 8'h3c},
        '{4'h4, 8'h0f, 8'h0f}, '{4'h6, 8'h01, 8'h01}, '{4'h7, 8'h01, 8'h01}, '{4'h9, 8'h33, 8'h00}};

    // Short debounce periods keep the run brief; slow is well above fast
    ipr_input_port #(.PINS(8), .SLOW_CYCLES(16), .FAST_CYCLES(4)) u_dut (.clk_sys(clk_sys),
        .rstn(rstn), .input_pins(input_pins), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pullup_enable_bits(pullup_enable_bits), .pin_irq_lines(pin_irq_lines),
        .mid_priority_irq_flags(mid_priority_irq_flags),
        .low_priority_irq_flags(low_priority_irq_flags), .event_flags(event_flags),
        .counter_clock_images(counter_clock_images), .port_reset_request(port_reset_request),
        .rc_oscillator_enable(rc_oscillator_enable));
    ipr_pin_source u_src (.clk_sys(clk_sys), .drive_en(drive_en), .drive_val(drive_val),
        .pullup_enable_bits(pullup_enable_bits), .input_pins(input_pins));

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Strobe released with one idle cycle, so two calls never collide in one step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [3:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
        @(posedge clk_sys);
    endtask

    task automatic watch(input int n);
        irq_acc = 8'h00;
        mid_acc = 8'h00;
        low_acc = 8'h00;
        evt_acc = 8'h00;
        repeat (n) begin
            #1;
            irq_acc |= pin_irq_lines;
            mid_acc |= mid_priority_irq_flags;
            low_acc |= low_priority_irq_flags;
            evt_acc |= event_flags;
            @(posedge clk_sys);
        end
    endtask

    task automatic pins(input logic [7:0] v, input int n);
        drive_val <= v;
        watch(n);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            check(rd_val, rows[i].e);
        end
        check(pullup_enable_bits, 8'h3c);
        $display("register table done");
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        for (int a = 1; a < 8; a++) begin
            rd(a[3:0]);
            check(rd_val, 8'h00);
        end
        check(pullup_enable_bits, 8'h00);
        $display("reset values done");
        pins(8'hff, 10);
        check(mid_acc, 8'h33);
        check(low_acc, 8'hcc);
        check(evt_acc, 8'h11);
        rd(4'h0);
        check(rd_val, 8'hff);
        check({4'h0, counter_clock_images}, 8'h0f);
        pins(8'h00, 10);
        check(irq_acc, 8'h00);
        wr(4'h2, 8'hff);
        watch(8);
        check(irq_acc, 8'hff);
        pins(8'hff, 10);
        check(irq_acc, 8'h00);
        pins(8'h00, 10);
        check(irq_acc, 8'hff);
        wr(4'h2, 8'h00);
        $display("edges done");
        wr(4'h1, 8'h01);
        wr(4'h6, 8'h00);
        // Pulse outlasts the synchroniser but never meets two slow ticks
        pins(8'h01, 6);
        check(irq_acc, 8'h00);
        pins(8'h00, 40);
        check(irq_acc, 8'h00);
        pins(8'h01, 12);
        check(irq_acc, 8'h00);
        rd(4'h0);
        check(rd_val, 8'h00);
        watch(40);
        check(irq_acc, 8'h01);
        rd(4'h0);
        check(rd_val, 8'h01);
        wr(4'h6, 8'h01);
        pins(8'h00, 14);
        rd(4'h0);
        check(rd_val, 8'h00);
        wr(4'h1, 8'h00);
        $display("debounce done");
        pins(8'ha5, 8);
        wr(4'h4, 8'h00);
        wr(4'h5, 8'h5a);
        wr(4'h4, 8'ha5);
        watch(3);
        check({7'h0, port_reset_request}, 8'h01);
        pins(8'ha4, 8);
        check({7'h0, port_reset_request}, 8'h00);
        wr(4'h4, 8'hff);
        wr(4'h5, 8'hff);
        pins(8'h5b, 8);
        check({7'h0, port_reset_request}, 8'h01);
        wr(4'h4, 8'h00);
        wr(4'h5, 8'h00);
        watch(3);
        check({7'h0, port_reset_request}, 8'h00);
        $display("port reset done");
        pins(8'ha5, 8);
        wr(4'h6, 8'h00);
        wr(4'h7, 8'h00);
        check({7'h0, rc_oscillator_enable}, 8'h00);
        wr(4'h6, 8'h02);
        watch(3);
        check({7'h0, rc_oscillator_enable}, 8'h01);
        wr(4'h3, 8'hff);
        drive_en <= 8'h00;
        watch(8);
        rd(4'h0);
        check(rd_val, 8'hff);
        $display("rc and pull-up done");
        print_verdict();
    end
endmodule
